// ---- pmp_pkg.sv ----
// Purpose: constants shared by the port pin configuration block
// Assumes: 8-bit cpu register file port, one clock
// Notes: offsets are cpu register-file addresses
package pmp_pkg;
    // register addresses
    localparam logic [7:0] ADDR_P1_IRQ_ENABLE = 8'hE6;
    localparam logic [7:0] ADDR_P1_IRQ_PENDING = 8'hE7;
    localparam logic [7:0] ADDR_P2_MODE_HIGH = 8'hE8;
    localparam logic [7:0] ADDR_P2_MODE_LOW = 8'hE9;
    localparam logic [7:0] ADDR_P3_MODE_HIGH = 8'hEA;
    localparam logic [7:0] ADDR_P3_MODE_LOW = 8'hEB;
    localparam logic [7:0] ADDR_PG2_CONTROL = 8'hEF;
    // reset value of every register
    localparam logic [7:0] REG_RESET = 8'h00;
    // drive type bits inside the port group two control
    localparam int PG2_SER1_OD_BIT = 7;
    localparam int PG2_SER0_OD_BIT = 6;
    // port three pins with alternate functions
    localparam int P3_SER1_DIN_PIN = 6;
    localparam int P3_SER1_DOUT_PIN = 5;
    localparam int P3_SER1_CLK_PIN = 4;
    localparam int P3_SER0_DIN_PIN = 3;
    localparam int P3_SER0_DOUT_PIN = 2;
    localparam int P3_SER0_CLK_PIN = 1;
    localparam int P3_BUZZER_PIN = 0;
    // two-bit pin mode codes
    localparam logic [1:0] MODE_INPUT = 2'h0;
    localparam logic [1:0] MODE_ALT1 = 2'h1;
    localparam logic [1:0] MODE_ALT2 = 2'h2;
    localparam logic [1:0] MODE_PUSH_PULL = 2'h3;
    // port one edge select codes
    localparam logic [1:0] EDGE_FALLING = 2'h0;
    localparam logic [1:0] EDGE_RISING = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
endpackage

// ---- pmp_edge_if.sv ----
// Purpose: carries one interrupt pin between top and edge detector
// Assumes: edge_sel is stable configuration
// Notes: hit is a one-cycle pulse
`timescale 1ns/10ps
interface pmp_edge_if;
    logic [1:0] edge_sel;
    logic pin_raw;
    logic hit;
    modport det (input edge_sel, input pin_raw, output hit);
    modport ctl (output edge_sel, output pin_raw, input hit);
endinterface

// ---- pmp_edge_det.sv ----
// Purpose: synchronise one interrupt pin and detect the chosen edge
// Assumes: pin is asynchronous to i_sys_clk
// Notes: output mode code never reports an edge
`timescale 1ns/10ps
module pmp_edge_det (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // pin and edge report
    pmp_edge_if.det ep
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic [2:0] armed;
    } pmp_edge_state_t;

    pmp_edge_state_t st, next_st;
    logic rise, fall;

    // two-flop synchroniser, then previous sample
    always_comb begin
        next_st = st;
        next_st.sync1 = ep.pin_raw;
        next_st.sync2 = st.sync1;
        next_st.prev = st.sync2;
        // fills with ones once the history holds real pin samples
        next_st.armed = {st.armed[1:0], 1'b1};
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // history is cleared by reset, so edges wait for three samples;
    // otherwise a pin idling high would report a false rise
    assign rise = st.armed[2] & st.sync2 & ~st.prev;
    assign fall = st.armed[2] & ~st.sync2 & st.prev;

    always_comb begin
        case (ep.edge_sel)
            pmp_pkg::EDGE_FALLING: ep.hit = fall;
            pmp_pkg::EDGE_RISING: ep.hit = rise;
            pmp_pkg::EDGE_BOTH: ep.hit = rise | fall;
            default: ep.hit = 1'b0;
        endcase
    end
endmodule

// ---- pmp_port_cfg.sv ----
// Purpose: port one pending flags, port two and three pin configuration
// Assumes: cpu register port, access valid for one cycle per strobe
// Notes: pin drive outputs are registered, two cycles after a write
`timescale 1ns/10ps
module pmp_port_cfg (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // cpu register port
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_direct,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_hit,
    // port one interrupt pins and edge selection
    input wire logic [7:0] i_p1_pin,
    input wire logic [15:0] i_p1_edge_sel,
    output logic [7:0] o_p1_irq_req,
    // port two pins
    input wire logic [7:0] i_p2_data,
    output logic [7:0] o_p2_out,
    output logic [7:0] o_p2_oe,
    output logic [7:0] o_p2_pullup,
    output logic [7:0] o_analog_channel_sel,
    // port three pins
    input wire logic [7:0] i_p3_pin,
    input wire logic [7:0] i_p3_data,
    output logic [7:0] o_p3_out,
    output logic [7:0] o_p3_oe,
    output logic [7:0] o_p3_pullup,
    // serial units and buzzer
    input wire logic i_serial0_data_out,
    input wire logic i_serial0_clock_out,
    input wire logic i_serial1_data_out,
    input wire logic i_serial1_clock_out,
    input wire logic i_buzzer_output,
    output logic o_serial0_data_in,
    output logic o_serial0_clock_in,
    output logic o_serial1_data_in,
    output logic o_serial1_clock_in
);
    typedef struct packed {
        // cpu-visible registers
        logic [7:0] pending;
        logic [7:0] enable;
        logic [7:0] p2_high;
        logic [7:0] p2_low;
        logic [7:0] p3_high;
        logic [7:0] p3_low;
        logic [7:0] pg2;

        // read port
        logic [7:0] rdata;
        logic hit;

        // port three pin synchroniser
        logic [7:0] p3_s1;
        logic [7:0] p3_s2;

        // registered pin drive
        logic [7:0] p2_out;
        logic [7:0] p2_oe;
        logic [7:0] p2_pu;
        logic [7:0] adc;
        logic [7:0] p3_out;
        logic [7:0] p3_oe;
        logic [7:0] p3_pu;

        // serial unit inputs
        logic s0_din;
        logic s0_clk;
        logic s1_din;
        logic s1_clk;
    } pmp_top_state_t;

    pmp_top_state_t st, next_st;
    logic [7:0] edge_hit;
    logic wr_ok, rd_ok;
    logic [15:0] p2_modes, p3_modes;

    // edge detectors for the eight interrupt lines
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : gen_edge
            pmp_edge_if eif ();
            assign eif.pin_raw = i_p1_pin[g];
            assign eif.edge_sel = i_p1_edge_sel[2*g +: 2];
            assign edge_hit[g] = eif.hit;
            pmp_edge_det u_det (
                .i_sys_clk(i_sys_clk),
                .i_rst(i_rst),
                .ep(eif.det)
            );
        end
    endgenerate

    assign wr_ok = i_reg_wr & i_reg_direct;
    assign rd_ok = i_reg_rd & i_reg_direct;

    assign p2_modes = {st.p2_high, st.p2_low};
    assign p3_modes = {st.p3_high, st.p3_low};

    // register writes, pending update and pin configuration
    always_comb begin
        logic [1:0] m;
        logic alt_val;
        logic alt_od;
        logic alt_ok;
        logic [7:0] clr;
        m = 2'h0;
        alt_val = 1'b0;
        alt_od = 1'b0;
        alt_ok = 1'b0;
        clr = 8'h00;
        next_st = st;

        // pin input synchroniser, two flops before any use
        next_st.p3_s1 = i_p3_pin;
        next_st.p3_s2 = st.p3_s1;

        if (wr_ok && i_reg_addr == pmp_pkg::ADDR_P1_IRQ_PENDING) begin
            clr = ~i_reg_wdata;
        end
        // an edge in the same cycle as a clear keeps the flag, so a request
        // arriving while software clears an older one is never lost
        // set beats clear, ones ignored
        next_st.pending = (st.pending & ~clr) | edge_hit;

        // plain register writes
        if (wr_ok) begin
            case (i_reg_addr)
                pmp_pkg::ADDR_P1_IRQ_ENABLE: next_st.enable = i_reg_wdata;
                pmp_pkg::ADDR_P2_MODE_HIGH: next_st.p2_high = i_reg_wdata;
                pmp_pkg::ADDR_P2_MODE_LOW: next_st.p2_low = i_reg_wdata;
                pmp_pkg::ADDR_P3_MODE_HIGH: next_st.p3_high = i_reg_wdata;
                pmp_pkg::ADDR_P3_MODE_LOW: next_st.p3_low = i_reg_wdata;
                pmp_pkg::ADDR_PG2_CONTROL: next_st.pg2 = i_reg_wdata;
                default: ;
            endcase
        end

        // read data, unmapped addresses answer zero
        // data is taken from the registers as they stand before this edge
        next_st.hit = 1'b0;
        if (rd_ok) begin
            next_st.hit = 1'b1;
            case (i_reg_addr)
                pmp_pkg::ADDR_P1_IRQ_ENABLE: next_st.rdata = st.enable;
                pmp_pkg::ADDR_P1_IRQ_PENDING: next_st.rdata = st.pending;
                pmp_pkg::ADDR_P2_MODE_HIGH: next_st.rdata = st.p2_high;
                pmp_pkg::ADDR_P2_MODE_LOW: next_st.rdata = st.p2_low;
                pmp_pkg::ADDR_P3_MODE_HIGH: next_st.rdata = st.p3_high;
                pmp_pkg::ADDR_P3_MODE_LOW: next_st.rdata = st.p3_low;
                pmp_pkg::ADDR_PG2_CONTROL: next_st.rdata = st.pg2;
                default: begin
                    next_st.rdata = 8'h00;
                    next_st.hit = 1'b0;
                end
            endcase
        end

        // port two pins
        for (int i = 0; i < 8; i++) begin
            m = p2_modes[2*i +: 2];
            next_st.p2_pu[i] = (m == pmp_pkg::MODE_ALT1);
            next_st.adc[i] = (m == pmp_pkg::MODE_ALT2);
            next_st.p2_oe[i] = (m == pmp_pkg::MODE_PUSH_PULL);
            next_st.p2_out[i] = (m == pmp_pkg::MODE_PUSH_PULL) & i_p2_data[i];
        end

        // port three pins
        for (int i = 0; i < 8; i++) begin
            m = p3_modes[2*i +: 2];
            alt_ok = 1'b1;
            case (i)
                pmp_pkg::P3_SER1_DOUT_PIN: begin
                    alt_val = i_serial1_data_out;
                    alt_od = st.pg2[pmp_pkg::PG2_SER1_OD_BIT];
                end
                pmp_pkg::P3_SER1_CLK_PIN: begin
                    alt_val = i_serial1_clock_out;
                    alt_od = st.pg2[pmp_pkg::PG2_SER1_OD_BIT];
                end
                pmp_pkg::P3_SER0_DOUT_PIN: begin
                    alt_val = i_serial0_data_out;
                    alt_od = st.pg2[pmp_pkg::PG2_SER0_OD_BIT];
                end
                pmp_pkg::P3_SER0_CLK_PIN: begin
                    alt_val = i_serial0_clock_out;
                    alt_od = st.pg2[pmp_pkg::PG2_SER0_OD_BIT];
                end
                pmp_pkg::P3_BUZZER_PIN: begin
                    alt_val = i_buzzer_output;
                    alt_od = 1'b0;
                end
                // pins 7, 6 and 3 have no alternate output
                default: begin
                    alt_val = 1'b0;
                    alt_od = 1'b0;
                    alt_ok = 1'b0;
                end
            endcase
            next_st.p3_pu[i] = 1'b0;
            case (m)
                pmp_pkg::MODE_ALT1: begin
                    // open-drain drives low only
                    next_st.p3_out[i] = 1'b0;
                    next_st.p3_oe[i] = ~i_p3_data[i];
                    next_st.p3_pu[i] = (i == pmp_pkg::P3_SER1_CLK_PIN);
                end
                pmp_pkg::MODE_ALT2: begin
                    next_st.p3_out[i] = alt_ok & ~alt_od & alt_val;
                    next_st.p3_oe[i] = alt_ok & (~alt_od | ~alt_val);
                end
                pmp_pkg::MODE_PUSH_PULL: begin
                    next_st.p3_out[i] = i_p3_data[i];
                    next_st.p3_oe[i] = 1'b1;
                end
                default: begin
                    next_st.p3_out[i] = 1'b0;
                    next_st.p3_oe[i] = 1'b0;
                end
            endcase
        end

        // pin 6 feeds serial one data in code 00
        next_st.s1_din = (st.p3_high[5:4] == pmp_pkg::MODE_INPUT) &
            st.p3_s2[pmp_pkg::P3_SER1_DIN_PIN];
        // pin 4 feeds serial one clock in code 00
        next_st.s1_clk = (st.p3_high[1:0] == pmp_pkg::MODE_INPUT) &
            st.p3_s2[pmp_pkg::P3_SER1_CLK_PIN];
        // pin 3 feeds serial zero data in code 00
        next_st.s0_din = (st.p3_low[7:6] == pmp_pkg::MODE_INPUT) &
            st.p3_s2[pmp_pkg::P3_SER0_DIN_PIN];
        // pin 1 feeds serial zero clock in code 00
        next_st.s0_clk = (st.p3_low[3:2] == pmp_pkg::MODE_INPUT) &
            st.p3_s2[pmp_pkg::P3_SER0_CLK_PIN];
    end

    // state register
    // reset clears every register and drive, so all pins float as inputs
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // outputs
    assign o_reg_rdata = st.rdata;
    assign o_reg_hit = st.hit;
    assign o_p1_irq_req = st.pending & st.enable;

    // port two drive
    assign o_p2_out = st.p2_out;
    assign o_p2_oe = st.p2_oe;
    assign o_p2_pullup = st.p2_pu;
    assign o_analog_channel_sel = st.adc;

    // port three drive
    assign o_p3_out = st.p3_out;
    assign o_p3_oe = st.p3_oe;
    assign o_p3_pullup = st.p3_pu;

    // serial unit inputs, zero unless the pin is in code 00
    assign o_serial0_data_in = st.s0_din;
    assign o_serial0_clock_in = st.s0_clk;
    assign o_serial1_data_in = st.s1_din;
    assign o_serial1_clock_in = st.s1_clk;
endmodule

// ---- pmp_port_cfg_assertions.sv ----
// Purpose: port-level checks of the pin configuration block
// Assumes: pin outputs follow a register write two edges later
// Notes: bound onto every pmp_port_cfg
`timescale 1ns/10ps
module pmp_port_cfg_assertions (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // register port
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_direct,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    input wire logic o_reg_hit,
    // pin side
    input wire logic [7:0] o_p1_irq_req,
    input wire logic [7:0] o_p2_oe,
    input wire logic [7:0] o_p2_pullup,
    input wire logic [7:0] o_analog_channel_sel,
    input wire logic [7:0] o_p3_oe,
    input wire logic o_serial1_data_in
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    logic wr_ok;
    logic rd_ok;
    // per-pin match of a mode byte against one code, highest pin first
    function automatic logic [3:0] fld(logic [7:0] v, logic [1:0] c);
        return {v[7:6] == c, v[5:4] == c, v[3:2] == c, v[1:0] == c};
    endfunction
    // strobes the block accepts
    assign wr_ok = i_reg_wr && i_reg_direct;
    assign rd_ok = i_reg_rd && i_reg_direct;
    a_read_hit: assert property (
        rd_ok && i_reg_addr inside {[8'hE6:8'hEB], 8'hEF} |=> o_reg_hit)
        else $error("mapped read unanswered");
    a_indirect_quiet: assert property (
        i_reg_rd && !i_reg_direct |=> !o_reg_hit)
        else $error("indirect read answered");
    a_p2h_drive: assert property (
        wr_ok && i_reg_addr == 8'hE8 |-> ##2
        o_p2_oe[7:4] == fld($past(i_reg_wdata, 2), 2'h3))
        else $error("port two high drive wrong");
    a_p2l_pullup: assert property (
        wr_ok && i_reg_addr == 8'hE9 |-> ##2
        o_p2_pullup[3:0] == fld($past(i_reg_wdata, 2), 2'h1))
        else $error("port two low pull-up wrong");
    a_p2h_analog: assert property (
        wr_ok && i_reg_addr == 8'hE8 |-> ##2
        o_analog_channel_sel[7:4] == fld($past(i_reg_wdata, 2), 2'h2))
        else $error("analog select wrong");
    a_p3_reserved: assert property (
        wr_ok && i_reg_addr == 8'hEB && i_reg_wdata[7:6] == 2'h2
        |-> ##2 !o_p3_oe[3])
        else $error("reserved code drives pin");
    a_buzzer_drive: assert property (
        wr_ok && i_reg_addr == 8'hEB && i_reg_wdata[1:0] == 2'h2
        |-> ##2 o_p3_oe[0])
        else $error("buzzer pin not driven");
    a_ser1_gate: assert property (
        wr_ok && i_reg_addr == 8'hEA && i_reg_wdata[5:4] != 2'h0
        |-> ##2 !o_serial1_data_in)
        else $error("serial input not gated");
    a_req_drop: assert property (
        |($past(o_p1_irq_req) & ~o_p1_irq_req)
        |-> $past(wr_ok && i_reg_addr inside {8'hE6, 8'hE7}))
        else $error("request dropped without write");
    a_enable_off: assert property (
        wr_ok && i_reg_addr == 8'hE6 && i_reg_wdata == 8'h00
        |=> o_p1_irq_req == 8'h00)
        else $error("disabled line requests");
    // main scenarios
    c_read: cover property (rd_ok ##1 o_reg_hit);
    c_req: cover property ($rose(o_p1_irq_req[3]));
    c_buz: cover property (wr_ok && i_reg_addr == 8'hEB ##2 o_p3_oe[0]);
endmodule

bind pmp_port_cfg pmp_port_cfg_assertions pmp_port_cfg_assertions_inst (
    .i_sys_clk, .i_rst, .i_reg_addr, .i_reg_direct, .i_reg_wr, .i_reg_rd,
    .i_reg_wdata, .o_reg_hit, .o_p1_irq_req, .o_p2_oe, .o_p2_pullup,
    .o_analog_channel_sel, .o_p3_oe, .o_serial1_data_in);

// ---- pmp_pins_model.sv ----
// Purpose: port three pads and the serial and buzzer sources
// Assumes: an undriven pad shows the outside level set by the bench
// Notes: alternate sources are levels chosen by the bench
`timescale 1ns/10ps
module pmp_pins_model (
    // pad drive from the block
    input wire logic [7:0] i_p3_out,
    input wire logic [7:0] i_p3_oe,
    // outside levels
    input wire logic [7:0] i_ext_level,
    input wire logic [4:0] i_src,
    // resolved pads and sources
    output logic [7:0] o_p3_pin,
    output logic [4:0] o_alt
);
    // a driving block wins, else the outside level holds the pad
    assign o_p3_pin = (i_p3_oe & i_p3_out) | (~i_p3_oe & i_ext_level);
    assign o_alt = i_src; // buzzer, ser1 clk, ser1 data, ser0 clk, ser0 data
endmodule

// ---- pmp_port_cfg_tb.sv ----
// Purpose: self-checking bench of the pin configuration block
// Assumes: pin outputs follow a write two edges later
// Notes: one task a scenario
`timescale 1ns/10ps
module pmp_port_cfg_tb;
    logic i_sys_clk = 0;
    logic i_rst = 1;
    logic [7:0] addr = 0, wdata = 0, p1 = 8'hFF, p2d = 8'hA5, ext = 8'hFF;
    logic [7:0] p3d = 8'h00;
    logic direct = 1, wr = 0, rd = 0, hit;
    logic [7:0] rdata, req, p2o, p2oe, p2pu, adc, p3o, p3oe, p3pu, p3pin;
    logic [4:0] alt;
    logic [3:0] sin;
    logic [7:0] regs [7] = '{8'hE6, 8'hE7, 8'hE8, 8'hE9, 8'hEA, 8'hEB, 8'hEF};
    int failures = 0, cmp_count = 0, cycles = 0;

    pmp_port_cfg pmp_port_cfg_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_reg_addr(addr), .i_reg_direct(direct), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .o_reg_hit(hit), .i_p1_pin(p1), .i_p1_edge_sel(16'hC009),
        .o_p1_irq_req(req), .i_p2_data(p2d), .o_p2_out(p2o), .o_p2_oe(p2oe),
        .o_p2_pullup(p2pu), .o_analog_channel_sel(adc), .i_p3_pin(p3pin),
        .i_p3_data(p3d), .o_p3_out(p3o), .o_p3_oe(p3oe),
        .o_p3_pullup(p3pu), .i_serial0_data_out(alt[0]),
        .i_serial0_clock_out(alt[1]), .i_serial1_data_out(alt[2]),
        .i_serial1_clock_out(alt[3]), .i_buzzer_output(alt[4]),
        .o_serial0_data_in(sin[3]), .o_serial0_clock_in(sin[2]),
        .o_serial1_data_in(sin[1]), .o_serial1_clock_in(sin[0]));
    pmp_pins_model pmp_pins_model_inst (.i_p3_out(p3o), .i_p3_oe(p3oe),
        .i_ext_level(ext), .i_src(5'h16), .o_p3_pin(p3pin), .o_alt(alt));

    // clock and hang guard
    always #5 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            test_done;
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic wreg(input logic [7:0] a, d, input logic dr = 1'b1);
        @(posedge i_sys_clk);
        addr <= a;
        wdata <= d;
        direct <= dr;
        wr <= 1;
        @(posedge i_sys_clk);
        wr <= 0;
        direct <= 1;
    endtask
    task automatic rchk(input logic [7:0] a, exp, input logic eh = 1'b1,
        input logic dr = 1'b1);
        @(posedge i_sys_clk);
        addr <= a;
        direct <= dr;
        rd <= 1;
        @(posedge i_sys_clk);
        rd <= 0;
        direct <= 1;
        #1;
        chk(rdata, exp);
        chk({7'h00, hit}, {7'h00, eh});
    endtask

    // reset values, readback, unmapped and indirect access
    task automatic t_regs;
        foreach (regs[i]) rchk(regs[i], 8'h00);
        rchk(8'hE5, 8'h00, 1'b0);
        for (int i = 2; i < 7; i++) begin
            wreg(regs[i], 8'h5A + 8'(i));
            rchk(regs[i], 8'h5A + 8'(i));
        end
        wreg(8'hE8, 8'hFF, 1'b0);
        rchk(8'hE8, 8'h5C);
        rchk(8'hE9, 8'h5C, 1'b0, 1'b0);
    endtask
    // port two codes on all pins
    task automatic t_p2;
        wreg(8'hE8, 8'hE4);
        wreg(8'hE9, 8'h1B);
        settle(1);
        chk(p2oe, 8'h81);
        chk(p2o & p2oe, 8'h81);
        chk(p2pu, 8'h24);
        chk(adc, 8'h42);
    endtask
    // port three codes, alternates and drive type
    task automatic t_p3;
        wreg(8'hEA, 8'h4A);
        wreg(8'hEB, 8'hA6);
        wreg(8'hEF, 8'h80);
        settle(4);
        chk(p3oe, 8'h97);
        chk(p3o, 8'h01);
        chk({4'h0, sin}, 8'h02);
        wreg(8'hEF, 8'h40);
        settle(1);
        chk(p3oe, 8'hB7);
        chk(p3o, 8'h21);
        wreg(8'hEA, 8'h01);
        settle(1);
        chk(p3pu & 8'h10, 8'h10);
        wreg(8'hEB, 8'hFF);
        p3d <= 8'h05;
        settle(1);
        chk(p3oe & 8'h0F, 8'h0F);
        chk(p3o & 8'h0F, 8'h05);
    endtask
    // pending flags: edges, write one, enable, clear
    task automatic t_irq;
        wreg(8'hE6, 8'hFF);
        @(posedge i_sys_clk);
        p1 <= 8'h74;
        settle(6);
        rchk(8'hE7, 8'h0A);
        chk(req, 8'h0A);
        wreg(8'hE7, 8'hFF);
        rchk(8'hE7, 8'h0A);
        wreg(8'hE6, 8'h02);
        settle(1);
        chk(req, 8'h02);
        wreg(8'hE6, 8'h00, 1'b0);
        rchk(8'hE6, 8'h02);
        wreg(8'hE7, 8'hF5);
        rchk(8'hE7, 8'h00);
        chk(req, 8'h00);
        @(posedge i_sys_clk);
        p1 <= 8'hFF;
        settle(6);
        rchk(8'hE7, 8'h03);
        wreg(8'hE6, 8'h00);
        settle(1);
        chk(req, 8'h00);
    endtask

    task automatic test_done;
        $display("checks=%0d errors=%0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // reset, then every scenario
    initial begin
        repeat (5) @(posedge i_sys_clk);
        i_rst <= 0;
        t_regs;
        t_p2;
        t_p3;
        t_irq;
        test_done;
    end
endmodule
